// ===== include/srls_pkg.sv
// Shared constants and types of the signal router and line-state block
package srls_pkg;

   // ****************************************
   // Widths and gain format
   // ****************************************
   localparam int DW         = 16;
   localparam int GAIN_FRAC  = 12;
   localparam logic signed [15:0] GAIN_UNITY = 16'h1000;
   localparam logic signed [15:0] SMP_MAX    = 16'h7FFF;
   localparam logic signed [15:0] SMP_MIN    = 16'h8000;
   localparam logic signed [15:0] SMP_ZERO   = 16'h0000;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_ROUTE   = 8'h00;
   localparam logic [7:0] OFS_GAIN0   = 8'h04;
   localparam logic [7:0] OFS_THR0    = 8'h10;
   localparam logic [7:0] OFS_LINE    = 8'h28;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h2C;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h30;
   localparam int NUM_GAIN = 3;
   localparam int NUM_THR  = 6;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int POS_METER = 0;
   localparam int POS_DET   = 4;
   localparam int POS_MON   = 8;
   localparam int POS_TX    = 12;
   localparam int POS_STATE = 0;
   localparam int POS_INDET = 2;
   localparam int POS_CHG   = 0;

   // Gain and threshold indices
   localparam int G_EXT  = 0;
   localparam int G_MON  = 1;
   localparam int G_PLAY = 2;
   localparam int T_IOFF  = 0;
   localparam int T_IIDLE = 1;
   localparam int T_IDISC = 2;
   localparam int T_VIDLE = 3;
   localparam int T_VINUS = 4;
   localparam int T_VDISC = 5;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [3:0] {
      SRC_RX, SRC_HYB, SRC_TX, SRC_GEN, SRC_EXT, SRC_OFF,
      SRC_PLAY, SRC_MFILT, SRC_NOTCH
   } srls_src_e_t;

   typedef enum logic [1:0] {
      TX_GEN, TX_EXT, TX_SUM
   } srls_tx_e_t;

   typedef enum logic [1:0] {
      LS_ON_HOOK, LS_OFF_HOOK, LS_IN_USE, LS_DISC
   } srls_ls_t;

   // Reset values
   localparam logic [3:0] RST_METER = 4'h0;
   localparam logic [3:0] RST_DET   = 4'h0;
   localparam logic [3:0] RST_MON   = 4'h5;
   localparam logic [1:0] RST_TX    = 2'h0;
   localparam logic [15:0] RST_THR  = 16'h0000;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic signed [15:0] line_rx;
      logic signed [15:0] hybrid;
      logic signed [15:0] gen_sum;
      logic signed [15:0] gen_tx;
      logic signed [15:0] ext_raw;
      logic signed [15:0] play_raw;
      logic signed [15:0] meter_filt;
      logic signed [15:0] meter_notch;
   } srls_src_t;

   typedef struct packed {
      logic [15:0] loop_i;
      logic [15:0] line_v;
   } srls_meas_t;

   typedef struct packed {
      logic [15:0] i_off;
      logic [15:0] i_idle;
      logic [15:0] i_disc;
      logic [15:0] v_idle;
      logic [15:0] v_inuse;
      logic [15:0] v_disc;
   } srls_thr_t;

endpackage

// ===== rtl/srls_class.sv
// Line-state classifier over loop current and line voltage
`timescale 1ns/1ps
module srls_class
   import srls_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Measurement
   input  wire logic       meas_en,
   input  wire srls_meas_t meas,
   input  wire srls_thr_t  thr,
   // Result
   output srls_ls_t        state,
   output logic            indet,
   output logic            change
);

   srls_ls_t state_r;
   srls_ls_t state_nxt;
   logic     indet_r;
   logic     indet_nxt;
   logic     chg_r;
   logic     chg_nxt;

   always_comb begin
      state_nxt = state_r;
      indet_nxt = indet_r;
      if (meas_en) begin
         indet_nxt = 1'b0;
         if (meas.loop_i > thr.i_off) begin
            state_nxt = LS_OFF_HOOK;
         end else if (meas.loop_i < thr.i_idle && meas.line_v > thr.v_idle) begin
            state_nxt = LS_ON_HOOK;
         end else if (meas.line_v < thr.v_inuse && meas.loop_i < thr.i_idle) begin
            state_nxt = LS_IN_USE;
         end else if (meas.line_v < thr.v_disc && meas.loop_i < thr.i_disc) begin
            state_nxt = LS_DISC;
         end else begin
            indet_nxt = 1'b1;
         end
      end
      chg_nxt = (state_nxt != state_r) || (indet_nxt != indet_r);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= LS_ON_HOOK;
         indet_r <= 1'b0;
         chg_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         indet_r <= indet_nxt;
         chg_r   <= chg_nxt;
      end
   end

   assign state  = state_r;
   assign indet  = indet_r;
   assign change = chg_r;

endmodule

// ===== rtl/srls_gain.sv
// Signed fixed-point gain stage with saturation
`timescale 1ns/1ps
module srls_gain
   import srls_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   // Sample path
   input  wire logic               smp_en,
   input  wire logic signed [15:0] din,
   input  wire logic signed [15:0] gain,
   output logic signed [15:0]      dout
);

   logic signed [31:0] prod;
   logic signed [31:0] scaled;
   logic signed [15:0] dout_r;
   logic signed [15:0] dout_nxt;

   always_comb begin
      prod     = din * gain;
      scaled   = prod >>> GAIN_FRAC;
      dout_nxt = dout_r;
      if (smp_en) begin
         if (scaled > 32'sd32767) begin
            dout_nxt = SMP_MAX;
         end else if (scaled < -32'sd32768) begin
            dout_nxt = SMP_MIN;
         end else begin
            dout_nxt = scaled[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dout_r <= SMP_ZERO;
      end else begin
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;

endmodule

// ===== rtl/srls_top.sv
// Signal router and line-state classifier with AHB-Lite registers
//
// Contract
// - Level, frequency and distortion meters take the meter-selected stream.
// - Tone, FSK, CAS and pulse detectors plus capture take the detector stream.
// - Meter and detector choose receive, hybrid, transmit, generator, external or off.
// - Monitor defaults off; adds playback, meter filter output and notch residue.
// - Meter-output choice gives the metered stream after its optional filter.
// - Notch choice gives the metered stream after the notch filters.
// - Transmit defaults to generators; also external alone or generators plus external.
// - External, monitor and playback each scaled by own signed gain, unity default.
// - Off-hook whenever loop current exceeds the off-hook current threshold.
// - On-hook when current below idle threshold and voltage above idle threshold.
// - In-use when voltage below in-use threshold and current below idle threshold.
// - Disconnect when voltage and current below their disconnect thresholds and the in-use region not matched.
// - No region matched: keep previous state and set indeterminate flag.
`timescale 1ns/1ps
module srls_top
   import srls_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Sample streams
   input  wire logic        sample_en,
   input  wire srls_src_t   src,
   output logic [15:0]      meter_out,
   output logic [15:0]      det_out,
   output logic [15:0]      mon_out,
   output logic [15:0]      tx_out,
   output logic [15:0]      play_out,
   // Line measurement
   input  wire logic        meas_en,
   input  wire srls_meas_t  meas,
   output logic [1:0]       line_state,
   output logic             line_indet,
   // Interrupt
   output logic             irq
);

   // ****************************************
   // Bus address phase capture
   // ****************************************
   logic        ph_wr_r;
   logic        ph_wr_nxt;
   logic [7:0]  ph_addr_r;
   logic [7:0]  ph_addr_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        take;
   assign take = hsel && htrans[1] && hready;

   // ****************************************
   // Register state
   // ****************************************
   logic [3:0]         sel_meter_r;
   logic [3:0]         sel_meter_nxt;
   logic [3:0]         sel_det_r;
   logic [3:0]         sel_det_nxt;
   logic [3:0]         sel_mon_r;
   logic [3:0]         sel_mon_nxt;
   logic [1:0]         sel_tx_r;
   logic [1:0]         sel_tx_nxt;
   logic signed [15:0] gain_r [NUM_GAIN];
   logic [15:0]        thr_r  [NUM_THR];
   logic               irq_st_r;
   logic               irq_st_nxt;
   logic               irq_msk_r;
   logic               irq_msk_nxt;
   logic               wr_route;
   logic               wr_irq_st;
   logic               wr_irq_msk;
   // Classifier link
   srls_thr_t thr;
   srls_ls_t  cls_state;
   logic      cls_indet;
   logic      cls_change;
   always_comb begin
      ph_wr_nxt   = 1'b0;
      ph_addr_nxt = ph_addr_r;
      rdata_nxt   = rdata_r;
      if (take) begin
         ph_wr_nxt   = hwrite && haddr[31:8] == 24'h00_0000;
         ph_addr_nxt = haddr[7:0];
         rdata_nxt   = 32'h0000_0000;
         if (!hwrite && haddr[31:8] == 24'h00_0000) begin
            unique case (haddr[7:0])
               OFS_ROUTE: begin
                  rdata_nxt[POS_METER+:4] = sel_meter_r;
                  rdata_nxt[POS_DET+:4]   = sel_det_r;
                  rdata_nxt[POS_MON+:4]   = sel_mon_r;
                  rdata_nxt[POS_TX+:2]    = sel_tx_r;
               end
               OFS_GAIN0:      rdata_nxt[15:0] = gain_r[G_EXT];
               OFS_GAIN0 + 8'h04: rdata_nxt[15:0] = gain_r[G_MON];
               OFS_GAIN0 + 8'h08: rdata_nxt[15:0] = gain_r[G_PLAY];
               OFS_THR0:          rdata_nxt[15:0] = thr_r[T_IOFF];
               OFS_THR0 + 8'h04:  rdata_nxt[15:0] = thr_r[T_IIDLE];
               OFS_THR0 + 8'h08:  rdata_nxt[15:0] = thr_r[T_IDISC];
               OFS_THR0 + 8'h0C:  rdata_nxt[15:0] = thr_r[T_VIDLE];
               OFS_THR0 + 8'h10:  rdata_nxt[15:0] = thr_r[T_VINUS];
               OFS_THR0 + 8'h14:  rdata_nxt[15:0] = thr_r[T_VDISC];
               OFS_LINE: begin
                  rdata_nxt[POS_STATE+:2] = cls_state;
                  rdata_nxt[POS_INDET]    = cls_indet;
               end
               OFS_IRQ_ST:     rdata_nxt[POS_CHG] = irq_st_r;
               OFS_IRQ_MSK:    rdata_nxt[POS_CHG] = irq_msk_r;
               default:        rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 8'h00;
         rdata_r   <= 32'h0000_0000;
      end else begin
         ph_wr_r   <= ph_wr_nxt;
         ph_addr_r <= ph_addr_nxt;
         rdata_r   <= rdata_nxt;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;

   // ****************************************
   // Control and interrupt registers
   // ****************************************
   assign wr_route   = ph_wr_r && ph_addr_r == OFS_ROUTE;
   assign wr_irq_st  = ph_wr_r && ph_addr_r == OFS_IRQ_ST;
   assign wr_irq_msk = ph_wr_r && ph_addr_r == OFS_IRQ_MSK;
   always_comb begin
      sel_meter_nxt = sel_meter_r;
      sel_det_nxt   = sel_det_r;
      sel_mon_nxt   = sel_mon_r;
      sel_tx_nxt    = sel_tx_r;
      irq_msk_nxt   = irq_msk_r;
      if (wr_route) begin
         sel_meter_nxt = hwdata[POS_METER+:4];
         sel_det_nxt   = hwdata[POS_DET+:4];
         sel_mon_nxt   = hwdata[POS_MON+:4];
         sel_tx_nxt    = hwdata[POS_TX+:2];
      end
      if (wr_irq_msk) begin
         irq_msk_nxt = hwdata[POS_CHG];
      end
      irq_st_nxt = (irq_st_r && !(wr_irq_st && hwdata[POS_CHG])) || cls_change;
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sel_meter_r <= RST_METER;
         sel_det_r   <= RST_DET;
         sel_mon_r   <= RST_MON;
         sel_tx_r    <= RST_TX;
         irq_st_r    <= 1'b0;
         irq_msk_r   <= 1'b0;
      end else begin
         sel_meter_r <= sel_meter_nxt;
         sel_det_r   <= sel_det_nxt;
         sel_mon_r   <= sel_mon_nxt;
         sel_tx_r    <= sel_tx_nxt;
         irq_st_r    <= irq_st_nxt;
         irq_msk_r   <= irq_msk_nxt;
      end
   end
   assign irq = irq_st_r && irq_msk_r;

   // ****************************************
   // Gain and threshold registers
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_GAIN; gi++) begin : g_gain
         logic signed [15:0] g_nxt;
         always_comb begin
            g_nxt = gain_r[gi];
            if (ph_wr_r && ph_addr_r == OFS_GAIN0 + 8'(4 * gi)) begin
               g_nxt = hwdata[15:0];
            end
         end
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               gain_r[gi] <= GAIN_UNITY;
            end else begin
               gain_r[gi] <= g_nxt;
            end
         end
      end
      for (gi = 0; gi < NUM_THR; gi++) begin : g_thr
         logic [15:0] t_nxt;
         always_comb begin
            t_nxt = thr_r[gi];
            if (ph_wr_r && ph_addr_r == OFS_THR0 + 8'(4 * gi)) begin
               t_nxt = hwdata[15:0];
            end
         end
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               thr_r[gi] <= RST_THR;
            end else begin
               thr_r[gi] <= t_nxt;
            end
         end
      end
   endgenerate
   // Descending order of thresholds is left to software
   assign thr = '{i_off: thr_r[T_IOFF], i_idle: thr_r[T_IIDLE], i_disc: thr_r[T_IDISC],
                  v_idle: thr_r[T_VIDLE], v_inuse: thr_r[T_VINUS], v_disc: thr_r[T_VDISC]};

   // ****************************************
   // Gain stages
   // ****************************************
   logic signed [15:0] g_out [NUM_GAIN];
   logic signed [15:0] ext_g;
   logic signed [15:0] play_g;
   logic signed [15:0] mon_g;
   logic signed [15:0] mon_pre_r;
   logic signed [15:0] mon_pre_nxt;
   assign ext_g  = g_out[G_EXT];
   assign mon_g  = g_out[G_MON];
   assign play_g = g_out[G_PLAY];
   for (gi = 0; gi < NUM_GAIN; gi++) begin : g_stage
      srls_gain u_gain (
         .clk_sys (clk_sys),
         .sys_rst (sys_rst),
         .smp_en  (sample_en),
         .din     (gi == G_EXT ? src.ext_raw : (gi == G_MON ? mon_pre_r : src.play_raw)),
         .gain    (gain_r[gi]),
         .dout    (g_out[gi])
      );
   end

   // ****************************************
   // Routing
   // ****************************************
   logic signed [15:0] meter_r;
   logic signed [15:0] meter_nxt;
   logic signed [15:0] det_r;
   logic signed [15:0] det_nxt;
   logic signed [15:0] tx_r;
   logic signed [15:0] tx_nxt;
   logic signed [16:0] tx_sum;
   function automatic logic signed [15:0] pick(input logic [3:0] sel, input srls_src_t s,
                                               input logic signed [15:0] tx, input logic signed [15:0] ext);
      logic signed [15:0] v;
      v = SMP_ZERO;
      case (sel)
         SRC_RX:  v = s.line_rx;
         SRC_HYB: v = s.hybrid;
         SRC_TX:  v = tx;
         SRC_GEN: v = s.gen_sum;
         SRC_EXT: v = ext;
         default: v = SMP_ZERO;
      endcase
      return v;
   endfunction
   always_comb begin
      tx_sum      = 17'(src.gen_tx) + 17'(ext_g);
      meter_nxt   = meter_r;
      det_nxt     = det_r;
      tx_nxt      = tx_r;
      mon_pre_nxt = mon_pre_r;
      if (sample_en) begin
         meter_nxt = pick(sel_meter_r, src, tx_r, ext_g);
         det_nxt   = pick(sel_det_r, src, tx_r, ext_g);
         unique case (sel_tx_r)
            TX_EXT:  tx_nxt = ext_g;
            TX_SUM: begin
               if (tx_sum > 17'sd32767) begin
                  tx_nxt = SMP_MAX;
               end else if (tx_sum < -17'sd32768) begin
                  tx_nxt = SMP_MIN;
               end else begin
                  tx_nxt = tx_sum[15:0];
               end
            end
            default: tx_nxt = src.gen_tx;
         endcase
         case (sel_mon_r)
            SRC_PLAY:  mon_pre_nxt = play_g;
            SRC_MFILT: mon_pre_nxt = src.meter_filt;
            SRC_NOTCH: mon_pre_nxt = src.meter_notch;
            default:   mon_pre_nxt = pick(sel_mon_r, src, tx_r, ext_g);
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meter_r   <= SMP_ZERO;
         det_r     <= SMP_ZERO;
         tx_r      <= SMP_ZERO;
         mon_pre_r <= SMP_ZERO;
      end else begin
         meter_r   <= meter_nxt;
         det_r     <= det_nxt;
         tx_r      <= tx_nxt;
         mon_pre_r <= mon_pre_nxt;
      end
   end
   assign meter_out = meter_r;
   assign det_out   = det_r;
   assign tx_out    = tx_r;
   assign mon_out   = mon_g;
   assign play_out  = play_g;

   // ****************************************
   // Line-state classifier
   // ****************************************
   srls_class u_class (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .meas_en (meas_en),
      .meas    (meas),
      .thr     (thr),
      .state   (cls_state),
      .indet   (cls_indet),
      .change  (cls_change)
   );
   assign line_state = cls_state;
   assign line_indet = cls_indet;
endmodule

// ===== testbench/signal_router_line_state_tb.sv
// Self-checking bench of the router and line-state block
`timescale 1ns/1ps
module signal_router_line_state_tb
   import srls_pkg::*;
;
   logic             clk_sys = 1'b0;
   logic             sys_rst = 1'b1;
   logic             hsel = 1'b0;
   logic [31:0]      haddr = '0;
   logic [1:0]       htrans = 2'b00;
   logic             hwrite = 1'b0;
   logic [31:0]      hwdata = '0;
   logic [31:0]      rd;
   wire logic        hreadyout, hresp, sample_en, meas_en, line_indet, irq;
   wire logic [31:0] hrdata;
   wire srls_src_t   src;
   wire srls_meas_t  meas;
   wire logic [15:0] meter_out, det_out, mon_out, tx_out, play_out;
   wire logic [1:0]  line_state;
   int               bad_count = 0;
   int               num_checks = 0;
   srls_src_t        s0 = 128'h0101_0202_0303_0404_0505_0606_0707_0808;

   always #4 clk_sys = ~clk_sys;

   srls_top DUT (
      .clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sample_en, .src, .meter_out,
      .det_out, .mon_out, .tx_out, .play_out, .meas_en, .meas, .line_state, .line_indet, .irq
   );
   srls_line_model PM (.clk_sys, .sample_en, .src, .meas_en, .meas);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk(32'h0, 32'h1);
         test_done();
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic t_reset;
      rdchk(OFS_ROUTE, 32'h0000_0500);
      rdchk(OFS_GAIN0 + 8'h04, 32'h0000_1000);
      ahb(1'b1, 8'h40, 32'h1234_5678);
      rdchk(8'h40, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_route;
      logic [15:0] e [6] = '{16'h0101, 16'h0202, 16'h0404, 16'h0303, 16'h0505, 16'h0000};
      for (int k = 0; k < 6; k++) begin
         ahb(1'b1, OFS_ROUTE, 32'h0000_0500 | (k << 4) | k);
         PM.play(s0, 2);
         @(negedge clk_sys);
         chk(meter_out, e[k]);
         chk(det_out, e[k]);
      end
      $display("test route done");
   endtask

   task automatic t_mon;
      logic [15:0] e [4] = '{16'h0000, 16'h0606, 16'h0707, 16'h0808};
      for (int k = 5; k < 9; k++) begin
         ahb(1'b1, OFS_ROUTE, k << 8);
         PM.play(s0, 3);
         @(negedge clk_sys);
         chk(mon_out, e[k-5]);
      end
      chk(play_out, 16'h0606);
      ahb(1'b1, OFS_GAIN0 + 8'h04, 32'h0000_F800);
      ahb(1'b1, OFS_GAIN0, 32'h0000_F800);
      ahb(1'b1, OFS_ROUTE, 32'h0000_0104);
      PM.play(s0, 3);
      @(negedge clk_sys);
      chk(mon_out, 16'hFEFF);
      chk(meter_out, 16'hFD7D);
      ahb(1'b1, OFS_GAIN0, 32'h0000_1000);
      $display("test monitor done");
   endtask

   task automatic t_tx;
      logic [15:0] e [4] = '{16'h0404, 16'h0505, 16'h0909, 16'h0404};
      for (int k = 0; k < 4; k++) begin
         ahb(1'b1, OFS_ROUTE, 32'h0000_0500 | (k << 12));
         PM.play(s0, 2);
         @(negedge clk_sys);
         chk(tx_out, e[k]);
      end
      $display("test transmit done");
   endtask

   task automatic meas_chk(input logic [15:0] i, input logic [15:0] v, input logic [2:0] e);
      PM.measure(i, v);
      @(negedge clk_sys);
      chk({line_indet, line_state}, e);
   endtask

   task automatic t_line;
      logic [15:0] th [6] = '{16'd100, 16'd50, 16'd20, 16'd300, 16'd200, 16'd100};
      logic [15:0] mi [5] = '{16'd150, 16'd10, 16'd10, 16'd60, 16'd10};
      logic [15:0] mv [5] = '{16'd0, 16'd400, 16'd150, 16'd250, 16'd50};
      logic [2:0]  ex [5] = '{3'h1, 3'h0, 3'h2, 3'h6, 3'h2};
      for (int k = 0; k < 6; k++) begin
         ahb(1'b1, OFS_THR0 + 8'(4 * k), {16'h0, th[k]});
      end
      ahb(1'b1, OFS_IRQ_MSK, 32'h1);
      for (int k = 0; k < 5; k++) begin
         meas_chk(mi[k], mv[k], ex[k]);
         chk(irq, 1'b1);
         ahb(1'b1, OFS_IRQ_ST, 32'h1);
         @(negedge clk_sys);
         chk(irq, 1'b0);
      end
      rdchk(OFS_LINE, 32'h2);
      ahb(1'b1, OFS_THR0 + 8'h10, 32'h0);
      meas_chk(16'd10, 16'd50, 3'h3);
      ahb(1'b1, OFS_IRQ_ST, 32'h1);
      ahb(1'b1, OFS_IRQ_MSK, 32'h0);
      meas_chk(16'd150, 16'd0, 3'h1);
      chk(irq, 1'b0);
      $display("test line done");
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_route();
      t_mon();
      t_tx();
      t_line();
      test_done();
   end
endmodule

// ===== testbench/srls_line_model.sv
// Line interface and rear-panel source model
`timescale 1ns/1ps
module srls_line_model
   import srls_pkg::*;
(
   // Clock
   input  wire logic  clk_sys,
   // Streams and measurement
   output logic       sample_en,
   output srls_src_t  src,
   output logic       meas_en,
   output srls_meas_t meas
);
   initial begin
      sample_en = 1'b0;
      meas_en = 1'b0;
      src = '0;
      meas = '0;
   end

   // Sample pulses; inputs scrambled between them
   task automatic play(input srls_src_t s, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         sample_en <= 1'b1;
         src <= s;
         @(posedge clk_sys);
         sample_en <= 1'b0;
         src <= ~s;
      end
   endtask

   // One measurement, then one edge for the event
   task automatic measure(input logic [15:0] i, input logic [15:0] v);
      @(posedge clk_sys);
      meas_en <= 1'b1;
      meas <= {i, v};
      @(posedge clk_sys);
      meas_en <= 1'b0;
      meas <= ~{i, v};
      @(posedge clk_sys);
   endtask
endmodule

// ===== testbench/srls_top_properties.sv
// Port checker of the router and line-state top
`timescale 1ns/1ps
module srls_top_properties
   import srls_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Bus
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Streams
   input wire logic        sample_en,
   input wire logic [15:0] meter_out,
   input wire logic [15:0] det_out,
   input wire logic [15:0] mon_out,
   input wire logic [15:0] tx_out,
   input wire logic [15:0] play_out,
   // Line
   input wire logic        meas_en,
   input wire logic [1:0]  line_state,
   input wire logic        line_indet,
   input wire logic        irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   zero_wait_a: assert property (hreadyout && !hresp)
      else $error("bus wait or error");
   upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
      else $error("read upper bits set");
   meter_hold_a: assert property (!sample_en |=> $stable(meter_out))
      else $error("meter stream moved");
   det_hold_a: assert property (!sample_en |=> $stable(det_out))
      else $error("detector stream moved");
   mon_hold_a: assert property (!sample_en |=> $stable(mon_out))
      else $error("monitor stream moved");
   tx_hold_a: assert property (!sample_en |=> $stable(tx_out))
      else $error("transmit stream moved");
   play_hold_a: assert property (!sample_en |=> $stable(play_out))
      else $error("playback stream moved");
   state_hold_a: assert property (!meas_en |=> $stable({line_indet, line_state}))
      else $error("line state moved");
   indet_keep_a: assert property (meas_en ##1 line_indet |-> $stable(line_state))
      else $error("state lost when undefined");

   cover property (meas_en ##1 line_state == LS_OFF_HOOK);
   cover property (meas_en ##1 line_indet);
   cover property ($rose(irq));
endmodule

bind srls_top srls_top_properties CHK (
   .clk_sys, .sys_rst, .hreadyout, .hresp, .hrdata, .sample_en, .meter_out, .det_out,
   .mon_out, .tx_out, .play_out, .meas_en, .line_state, .line_indet, .irq
);
